/* rtl/acr_defs.svh */
// acr_defs.svh: offsets, field positions and reset values of the converter control block
// assumes: included by bare name from the design file
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACR_OFS_STATUS 8'h00
`define ACR_OFS_CTRL1 8'h04
// ----------------------------------------
// control register one fields
// ----------------------------------------
`define ACR_BIT_REG_WDOG 23
`define ACR_BIT_INJ_WDOG 22
`define ACR_DISC_HI 15
`define ACR_DISC_LO 13
`define ACR_BIT_INJ_DISC 12
`define ACR_BIT_REG_DISC 11
`define ACR_BIT_AUTO 10
`define ACR_BIT_SINGLE 9
`define ACR_BIT_SCAN 8
`define ACR_BIT_INJ_IE 7
`define ACR_BIT_WDOG_IE 6
`define ACR_BIT_DONE_IE 5
`define ACR_CH_HI 4
`define ACR_CH_LO 0
`define ACR_CTRL1_MASK 32'h00c0ffff
`define ACR_CTRL1_RESET 32'h00000000
// ----------------------------------------
// status register fields and watchdog high threshold reset value
// ----------------------------------------
`define ACR_BIT_INJ_DONE 2
`define ACR_BIT_DONE 1
`define ACR_BIT_WDOG_EVT 0
`define ACR_WDOG_HIGH_RESET 10'h3ff
`endif

/* rtl/acr_pkg.sv */
// acr_pkg.sv: types of the converter control block
// assumes: nothing; acr_defs.svh is not included here
package acr_pkg;
  // ----------------------------------------
  // configuration carried to the sequencer
  // ----------------------------------------
  typedef struct packed {
    logic regular_watchdog_enable;
    logic injected_watchdog_enable;
    logic [2:0] discontinuous_channel_count;
    logic injected_discontinuous_enable;
    logic regular_discontinuous_enable;
    logic auto_injected_after_regular;
    logic watchdog_single_channel;
    logic scan_enable;
    logic injected_done_irq_enable;
    logic watchdog_irq_enable;
    logic conversion_done_irq_enable;
    logic [4:0] watchdog_channel_select;
  } acr_cfg_t;
  // ----------------------------------------
  // one finished channel conversion
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic injected;
    logic [4:0] channel;
    logic [9:0] data;
  } acr_conv_t;
endpackage : acr_pkg

/* rtl/acr_ctrl.sv */
// acr_ctrl.sv: control register one of the converter, status flags, watchdog and irq
// assumes: converter core on the same clock; software on the plain register port
// Summary of operation
// - bit 23 enables the watchdog on regular-group conversions.
// - bit 22 enables the watchdog on injected-group conversions.
// - bits 15:13 give regular channels per trigger in discontinuous mode, value plus one.
// - bit 12 puts the injected group into discontinuous mode.
// - bit 11 puts the regular group into discontinuous mode.
// - bit 10 starts the injected group automatically after the regular group ends.
// - bit 9 limits the watchdog to the selected channel, else all channels.
// - bit 8 enables scan mode over all sequenced channels.
// - bit 7 raises an irq while the injected-done flag is set.
// - bit 6 raises an irq while the watchdog flag is set.
// - a watchdog irq during a scan aborts the rest of that scan.
// - bit 5 raises an irq while the conversion-done flag is set.
// - bits 4:0 select the watched channel, 0 to 31.
// - hardware sets the done flag at the end of a regular or injected group.
// - hardware sets the watchdog flag when a value leaves the threshold window.
// - single-channel scope with both enables guards that channel in both groups.
`include "acr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // converter core
  input wire acr_pkg::acr_conv_t conv_i,
  input wire logic regular_end_i,
  input wire logic injected_end_i,
  input wire logic seq_busy_i,
  input wire logic scan_active_i,
  input wire logic [DATA_W-1:0] wdog_high_i,
  input wire logic [DATA_W-1:0] wdog_low_i,
  // to sequencer and interrupt controller
  output acr_pkg::acr_cfg_t cfg_o,
  output logic injected_start_o,
  output logic scan_abort_o,
  output logic [3:0] disc_channels_o,
  output logic irq_o
);
  import acr_pkg::*;

  if (ADDR_W < 8 || DATA_W < 1 || DATA_W > 10) begin : g_bad_params
    $error("acr_ctrl: unsupported parameter values");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  acr_cfg_t shadow_reg, shadow_next;
  acr_cfg_t cfg_reg, cfg_next;
  logic done_flag_reg, done_flag_next;
  logic inj_flag_reg, inj_flag_next;
  logic wdog_flag_reg, wdog_flag_next;
  logic [31:0] rdata_reg, rdata_next;
  logic start_reg, start_next;
  logic abort_reg, abort_next;
  logic irq_reg, irq_next;
  logic [3:0] disc_reg, disc_next;
  logic wdog_hit;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] pack_ctrl(input acr_cfg_t c);
    logic [31:0] w;
    w = 32'h00000000;
    w[`ACR_BIT_REG_WDOG] = c.regular_watchdog_enable;
    w[`ACR_BIT_INJ_WDOG] = c.injected_watchdog_enable;
    w[`ACR_DISC_HI:`ACR_DISC_LO] = c.discontinuous_channel_count;
    w[`ACR_BIT_INJ_DISC] = c.injected_discontinuous_enable;
    w[`ACR_BIT_REG_DISC] = c.regular_discontinuous_enable;
    w[`ACR_BIT_AUTO] = c.auto_injected_after_regular;
    w[`ACR_BIT_SINGLE] = c.watchdog_single_channel;
    w[`ACR_BIT_SCAN] = c.scan_enable;
    w[`ACR_BIT_INJ_IE] = c.injected_done_irq_enable;
    w[`ACR_BIT_WDOG_IE] = c.watchdog_irq_enable;
    w[`ACR_BIT_DONE_IE] = c.conversion_done_irq_enable;
    w[`ACR_CH_HI:`ACR_CH_LO] = c.watchdog_channel_select;
    return w & `ACR_CTRL1_MASK;
  endfunction : pack_ctrl

  function automatic acr_cfg_t unpack_ctrl(input logic [31:0] w);
    acr_cfg_t c;
    c.regular_watchdog_enable = w[`ACR_BIT_REG_WDOG];
    c.injected_watchdog_enable = w[`ACR_BIT_INJ_WDOG];
    c.discontinuous_channel_count = w[`ACR_DISC_HI:`ACR_DISC_LO];
    c.injected_discontinuous_enable = w[`ACR_BIT_INJ_DISC];
    c.regular_discontinuous_enable = w[`ACR_BIT_REG_DISC];
    c.auto_injected_after_regular = w[`ACR_BIT_AUTO];
    c.watchdog_single_channel = w[`ACR_BIT_SINGLE];
    c.scan_enable = w[`ACR_BIT_SCAN];
    c.injected_done_irq_enable = w[`ACR_BIT_INJ_IE];
    c.watchdog_irq_enable = w[`ACR_BIT_WDOG_IE];
    c.conversion_done_irq_enable = w[`ACR_BIT_DONE_IE];
    c.watchdog_channel_select = w[`ACR_CH_HI:`ACR_CH_LO];
    return c;
  endfunction : unpack_ctrl

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return (a == ADDR_W'(ofs));
  endfunction : is_addr

  // ----------------------------------------
  // watchdog compare on the active settings
  // ----------------------------------------
  always_comb begin
    wdog_hit = 1'b0;
    if (conv_i.valid &&
        ((conv_i.injected && cfg_reg.injected_watchdog_enable) ||
         (!conv_i.injected && cfg_reg.regular_watchdog_enable)) &&
        (!cfg_reg.watchdog_single_channel ||
         conv_i.channel == cfg_reg.watchdog_channel_select) &&
        ((conv_i.data[DATA_W-1:0] > wdog_high_i) ||
         (conv_i.data[DATA_W-1:0] < wdog_low_i))) begin
      wdog_hit = 1'b1;
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    shadow_next = shadow_reg;
    cfg_next = cfg_reg;
    done_flag_next = done_flag_reg;
    inj_flag_next = inj_flag_reg;
    wdog_flag_next = wdog_flag_reg;
    rdata_next = 32'h00000000;
    start_next = 1'b0;
    abort_next = 1'b0;
    // register writes
    if (wr_i) begin
      if (is_addr(addr_i, `ACR_OFS_CTRL1)) begin
        shadow_next = unpack_ctrl(wdata_i);
      end else if (is_addr(addr_i, `ACR_OFS_STATUS)) begin
        if (!wdata_i[`ACR_BIT_DONE]) begin
          done_flag_next = 1'b0;
        end
        if (!wdata_i[`ACR_BIT_INJ_DONE]) begin
          inj_flag_next = 1'b0;
        end
        if (!wdata_i[`ACR_BIT_WDOG_EVT]) begin
          wdog_flag_next = 1'b0;
        end
      end
    end
    // register reads, data stand one cycle later
    if (rd_i) begin
      if (is_addr(addr_i, `ACR_OFS_CTRL1)) begin
        rdata_next = pack_ctrl(shadow_reg);
      end else if (is_addr(addr_i, `ACR_OFS_STATUS)) begin
        rdata_next[`ACR_BIT_DONE] = done_flag_reg;
        rdata_next[`ACR_BIT_INJ_DONE] = inj_flag_reg;
        rdata_next[`ACR_BIT_WDOG_EVT] = wdog_flag_reg;
      end
    end
    // hardware sets win over software clears
    if (regular_end_i || injected_end_i) begin
      done_flag_next = 1'b1;
    end
    if (injected_end_i) begin
      inj_flag_next = 1'b1;
    end
    if (wdog_hit) begin
      wdog_flag_next = 1'b1;
    end
    // settings move to the sequencer only between sequences
    if (!seq_busy_i) begin
      cfg_next = shadow_reg;
    end
    // automatic injected group, assumes injected external trigger is off
    if (regular_end_i && cfg_reg.auto_injected_after_regular) begin
      start_next = 1'b1;
    end
    // watchdog irq ends a running scan
    if (wdog_hit && cfg_reg.watchdog_irq_enable && cfg_reg.scan_enable && scan_active_i) begin
      abort_next = 1'b1;
    end
    disc_next = {1'b0, cfg_reg.discontinuous_channel_count} + 4'h1;
    irq_next = (done_flag_next && shadow_reg.conversion_done_irq_enable) ||
               (inj_flag_next && shadow_reg.injected_done_irq_enable) ||
               (wdog_flag_next && shadow_reg.watchdog_irq_enable);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shadow_reg <= '0;
      cfg_reg <= '0;
      done_flag_reg <= 1'b0;
      inj_flag_reg <= 1'b0;
      wdog_flag_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      irq_reg <= 1'b0;
      disc_reg <= 4'h1;
    end else begin
      shadow_reg <= shadow_next;
      cfg_reg <= cfg_next;
      done_flag_reg <= done_flag_next;
      inj_flag_reg <= inj_flag_next;
      wdog_flag_reg <= wdog_flag_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
      abort_reg <= abort_next;
      irq_reg <= irq_next;
      disc_reg <= disc_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata_o = rdata_reg;
  assign cfg_o = cfg_reg;
  assign injected_start_o = start_reg;
  assign scan_abort_o = abort_reg;
  assign disc_channels_o = disc_reg;
  assign irq_o = irq_reg;
endmodule : acr_ctrl
`default_nettype wire

/* dv/acr_ctrl_assertions.sv */
// acr_ctrl_assertions.sv: port checker for acr_ctrl
// assumes: bound to every acr_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module acr_ctrl_chk #(
  parameter int DATA_W = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire acr_pkg::acr_conv_t conv_i,
  input wire logic regular_end_i,
  input wire logic seq_busy_i,
  input wire logic scan_active_i,
  input wire logic [DATA_W-1:0] wdog_high_i,
  input wire logic [DATA_W-1:0] wdog_low_i,
  input wire acr_pkg::acr_cfg_t cfg_o,
  input wire logic injected_start_o,
  input wire logic scan_abort_o
);
  import acr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence reg_hit_s;
    conv_i.valid && !conv_i.injected && cfg_o.regular_watchdog_enable &&
      !cfg_o.watchdog_single_channel && (conv_i.data > wdog_high_i || conv_i.data < wdog_low_i);
  endsequence
  sequence inj_hit_s;
    conv_i.valid && conv_i.injected && cfg_o.injected_watchdog_enable &&
      cfg_o.watchdog_single_channel && conv_i.channel == cfg_o.watchdog_channel_select &&
      conv_i.data < wdog_low_i;
  endsequence
  sequence armed_s;
    cfg_o.scan_enable && cfg_o.watchdog_irq_enable && scan_active_i;
  endsequence
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read cycle");
  rsvd_zero_a: assert property (rdata_o[31:24] == 8'h00 && rdata_o[21:16] == 6'h00)
    else $error("reserved bits read nonzero");
  cfg_hold_a: assert property (seq_busy_i |=> $stable(cfg_o))
    else $error("settings changed during sequence");
  auto_start_a: assert property (regular_end_i && cfg_o.auto_injected_after_regular |=>
    injected_start_o)
    else $error("no auto injected start");
  start_cause_a: assert property (injected_start_o |->
    $past(regular_end_i) && $past(cfg_o.auto_injected_after_regular))
    else $error("auto injected start without cause");
  abort_cause_a: assert property (scan_abort_o |->
    $past(conv_i.valid) && $past(cfg_o.scan_enable) && $past(scan_active_i))
    else $error("abort without cause");
  reg_abort_a: assert property ((reg_hit_s and armed_s) |=> scan_abort_o)
    else $error("no abort after regular hit");
  inj_abort_a: assert property ((inj_hit_s and armed_s) |=> scan_abort_o)
    else $error("no abort after injected hit");
  single_miss_a: assert property (conv_i.valid && cfg_o.watchdog_single_channel &&
    conv_i.channel != cfg_o.watchdog_channel_select |=> !scan_abort_o)
    else $error("abort on unwatched channel");
endmodule : acr_ctrl_chk
bind acr_ctrl acr_ctrl_chk #(.DATA_W(DATA_W)) u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .conv_i(conv_i), .regular_end_i(regular_end_i),
  .seq_busy_i(seq_busy_i), .scan_active_i(scan_active_i), .wdog_high_i(wdog_high_i),
  .wdog_low_i(wdog_low_i), .cfg_o(cfg_o), .injected_start_o(injected_start_o),
  .scan_abort_o(scan_abort_o));
`default_nettype wire

/* dv/acr_core_model.sv */
// acr_core_model.sv: converter core stand-in giving conversions and group ends
// assumes: same clock as acr_ctrl; the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
module acr_core_model (
  input wire logic clk_i,
  output var acr_pkg::acr_conv_t conv_o,
  output logic reg_end_o,
  output logic inj_end_o
);
  import acr_pkg::*;
  initial begin
    conv_o = '0;
    reg_end_o = 1'b0;
    inj_end_o = 1'b0;
  end
  // one-cycle result; released fields go to the inverse
  task automatic conv(logic inj, logic [4:0] ch, logic [9:0] d);
    @(posedge clk_i);
    conv_o <= '{1'b1, inj, ch, d};
    @(posedge clk_i);
    conv_o <= '{1'b0, ~inj, ~ch, ~d};
    #1;
  endtask : conv
  task automatic done(logic inj);
    @(posedge clk_i);
    reg_end_o <= !inj;
    inj_end_o <= inj;
    @(posedge clk_i);
    reg_end_o <= 1'b0;
    inj_end_o <= 1'b0;
    #1;
  endtask : done
endmodule : acr_core_model
`default_nettype wire

/* dv/tb.sv */
// tb.sv: self-checking bench for acr_ctrl
// assumes: core model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0, rd_i = 1'b0, busy_i = 1'b0, scan_i = 1'b0;
  logic [9:0] hi_i = 10'h200, lo_i = 10'h010;
  logic [31:0] rdata_o;
  acr_conv_t conv;
  acr_cfg_t cfg_o;
  logic reg_end, inj_end, start_o, abort_o, irq_o;
  logic [3:0] disc_o;
  int errors = 0;
  int num_checks = 0;
  always #10 clk_i = ~clk_i;
  acr_core_model core (.clk_i(clk_i), .conv_o(conv), .reg_end_o(reg_end), .inj_end_o(inj_end));
  acr_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_i(conv), .regular_end_i(reg_end),
    .injected_end_i(inj_end), .seq_busy_i(busy_i), .scan_active_i(scan_i), .wdog_high_i(hi_i),
    .wdog_low_i(lo_i), .cfg_o(cfg_o), .injected_start_o(start_o), .scan_abort_o(abort_o),
    .disc_channels_o(disc_o), .irq_o(irq_o));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", e, rdata_o);
  endtask : rd
  task automatic t_regs();
    logic [31:0] p[2] = '{32'hffffffff, 32'hff3f5a5a};
    rd(8'h04, 32'h0);
    chk("cfg", 32'h0, 32'(cfg_o));
    chk("disc", 32'h1, 32'(disc_o));
    foreach (p[i]) begin
      wr(8'h04, p[i]);
      rd(8'h04, p[i] & 32'h00c0ffff);
      cyc(2);
      chk("cfg", {14'h0, p[i][23:22], p[i][15:0]}, 32'(cfg_o));
    end
    rd(8'h08, 32'h0);
    for (int n = 0; n < 8; n++) begin
      wr(8'h04, 32'(n) << 13);
      cyc(2);
      chk("disc", 32'(n + 1), 32'(disc_o));
    end
    @(posedge clk_i);
    busy_i <= 1'b1;
    wr(8'h04, 32'h00000100);
    cyc(3);
    chk("cfg", 32'h0000e000, 32'(cfg_o));
    @(posedge clk_i);
    busy_i <= 1'b0;
    cyc(3);
    chk("cfg", 32'h00000100, 32'(cfg_o));
    $display("test regs done");
  endtask : t_regs
  task automatic t_done();
    wr(8'h04, 32'h00000420);
    cyc(2);
    core.done(1'b0);
    chk("evt", 32'h5, 32'({start_o, abort_o, irq_o}));
    rd(8'h00, 32'h2);
    wr(8'h00, 32'h5);
    chk("irq", 32'h0, 32'(irq_o));
    wr(8'h04, 32'h00000080);
    cyc(2);
    core.done(1'b1);
    chk("evt", 32'h1, 32'({start_o, abort_o, irq_o}));
    rd(8'h00, 32'h6);
    wr(8'h00, 32'h0);
    core.done(1'b0);
    chk("evt", 32'h0, 32'({start_o, abort_o, irq_o}));
    wr(8'h00, 32'h0);
    $display("test done flags done");
  endtask : t_done
  task automatic t_wdog();
    wr(8'h04, 32'h00800140);
    @(posedge clk_i);
    scan_i <= 1'b1;
    core.conv(1'b0, 5'h05, 10'h300);
    chk("evt", 32'h3, 32'({start_o, abort_o, irq_o}));
    rd(8'h00, 32'h1);
    wr(8'h00, 32'h6);
    core.conv(1'b0, 5'h05, 10'h100);
    core.conv(1'b1, 5'h05, 10'h3ff);
    chk("evt", 32'h0, 32'({start_o, abort_o, irq_o}));
    wr(8'h04, 32'h00c0034f);
    cyc(2);
    core.conv(1'b1, 5'h03, 10'h000);
    chk("evt", 32'h0, 32'({start_o, abort_o, irq_o}));
    core.conv(1'b0, 5'h0f, 10'h3ff);
    chk("evt", 32'h3, 32'({start_o, abort_o, irq_o}));
    wr(8'h00, 32'h0);
    core.conv(1'b1, 5'h0f, 10'h000);
    chk("evt", 32'h3, 32'({start_o, abort_o, irq_o}));
    $display("test watchdog done");
  endtask : t_wdog
  task automatic t_reset();
    wr(8'h04, 32'h00c0ffff);
    core.done(1'b0);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    cyc(2);
    chk("cfg", 32'h0, 32'(cfg_o));
    chk("evt", 32'h0, 32'({start_o, abort_o, irq_o}));
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    chk("disc", 32'h1, 32'(disc_o));
    rd(8'h04, 32'h0);
    rd(8'h00, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_done();
    t_wdog();
    t_reset();
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
